//--- scp_asserts.sv
// Port checker for the serial command parser.
// Assumes ce_in stays high whenever timing is checked.
`timescale 1ns/1ns
module scp_asserts (
  input wire logic                     clk_in,
  input wire logic                     sys_rst_in,
  input wire logic                     ce_in,
  input wire logic                     rx_in,
  input wire logic                     tx_out,
  input wire logic                     ovl_input_in,
  input wire logic                     ovl_gain_in,
  input wire logic                     ovl_input_flag_out,
  input wire logic                     ovl_gain_flag_out,
  input wire logic [4:0]               sens_code_out,
  input wire logic [scp_pkg::VAL_W-1:0] sens_full_scale_uv_out,
  input wire logic [2:0]               ref_mode_out,
  input wire logic [scp_pkg::VAL_W-1:0] freq_out,
  input wire logic                     display_update_out,
  input wire logic                     busy_out
);
  import scp_pkg::*;
  int lo_cnt;
  // Low run length; every low run on the line is whole bit periods
  always_ff @(posedge clk_in) begin
    lo_cnt <= (sys_rst_in || tx_out) ? 0 : lo_cnt + 1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_OVL_INPUT: assert property (ce_in |=> ovl_input_flag_out == $past(ovl_input_in))
    else $error("input overload flag wrong");
  AST_OVL_GAIN: assert property (ce_in |=> ovl_gain_flag_out == $past(ovl_gain_in))
    else $error("gain overload flag wrong");
  AST_SENS_MAP: assert property (sens_full_scale_uv_out == (sens_code_out == 5'h19 ? 20'h186a0 :
    sens_code_out == 5'h18 ? 20'h0c350 : 20'h00000)) else $error("full scale decode wrong");
  AST_RESET_VAL: assert property ($fell(sys_rst_in) |-> sens_code_out == 5'h19 && freq_out == 20'h003e8
    && ref_mode_out == 3'h0 && tx_out && !busy_out) else $error("reset values wrong");
  AST_UPD_PULSE: assert property (ce_in && display_update_out |=> !display_update_out)
    else $error("refresh pulse too long");
  AST_UPD_CAUSE: assert property (ce_in && !$stable({sens_code_out, ref_mode_out, freq_out})
    |-> ##[0:1] display_update_out) else $error("change without refresh");
  AST_SET_BUSY: assert property (!$stable({sens_code_out, ref_mode_out, freq_out}) |-> $past(busy_out))
    else $error("setting changed outside execution");
  AST_UPD_BUSY: assert property (display_update_out |-> $past(busy_out))
    else $error("refresh outside execution");
  AST_TX_BIT: assert property ($rose(tx_out) |-> lo_cnt % BIT_CYCLES == 0)
    else $error("tx low run not whole bits");
  AST_CE_FREEZE: assert property (!ce_in |=> $stable({sens_code_out, ref_mode_out, freq_out, busy_out, tx_out,
    ovl_input_flag_out, ovl_gain_flag_out, display_update_out})) else $error("state moved with enable low");
endmodule // scp_asserts

//--- scp_host_model.sv
// Host terminal model: sends framed characters, collects reply characters.
// Assumes a 25 MHz clock shared with the parser; drives at falling edges.
`timescale 1ns/1ns
module scp_host_model (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  import scp_pkg::*;
  byte unsigned rx_q[$];
  int           bad_stop = 0;
  initial line_out = 1'b1;
  task automatic send_byte(input logic [7:0] b, input logic stop, input int gap);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out = f[i];
      repeat (BIT_CYCLES) @(negedge clk_in);
    end
    // Back-to-back frames leave the stop level standing
    if (gap > 0) begin
      line_out = 1'b1;
      repeat (gap) @(negedge clk_in);
    end
  endtask
  // A cleared stop bit at index bad breaks framing on purpose
  task automatic send_line(input string s, input int gap, input int bad);
    foreach (s[i]) send_byte(s[i], i != bad, gap);
    send_byte(CH_CR, 1'b1, gap);
  endtask
  always begin
    logic [7:0] d;
    @(negedge clk_in iff line_in == 1'b0);
    repeat (HALF_CYCLES) @(negedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(negedge clk_in);
      d[i] = line_in;
    end
    repeat (BIT_CYCLES) @(negedge clk_in);
    if (line_in !== 1'b1) bad_stop++;
    rx_q.push_back(d);
  end
endmodule // scp_host_model

//--- scp_line_mem.sv
// Line buffer for one received command line, registered read.
// Assumes the parser drives the ctrl modport on the same clock.
`timescale 1ns/1ns
module scp_line_mem (
  input  wire logic clk_in,
  input  wire logic ce_in,
  scp_mem_if.mem    port
);
  import scp_pkg::*;
  logic [7:0] mem_reg [0:(1<<ADDR_W)-1];
  logic [7:0] rd_reg;
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (port.wr_en) begin
        mem_reg[port.wr_addr] <= port.wr_data;
      end
      rd_reg <= mem_reg[port.rd_addr];
    end
  end
  assign port.rd_data = rd_reg;
endmodule // scp_line_mem

//--- scp_mem_if.sv
// Port bundle between the parser and its line memory.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface scp_mem_if;
  import scp_pkg::*;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

//--- scp_pkg.sv
// Constants shared by the serial command parser and its line memory.
// Assumes a 25 MHz system clock.
package scp_pkg;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned BAUD_RATE     = 921600;
  localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_RATE;
  localparam int unsigned HALF_CYCLES   = BIT_CYCLES / 2;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned ADDR_W        = 6;
  localparam int unsigned VAL_W         = 20;
  localparam int unsigned DIGITS        = 7;
  localparam logic [5:0]  LINE_MAX      = 6'h3f;
  localparam logic [7:0]  CH_CR         = 8'h0d;
  localparam logic [7:0]  CH_SEMI       = 8'h3b;
  localparam logic [7:0]  CH_SPACE      = 8'h20;
  localparam logic [7:0]  CH_QUERY      = 8'h3f;
  localparam logic [7:0]  CH_ZERO       = 8'h30;
  localparam logic [7:0]  CH_NINE       = 8'h39;
  localparam logic [31:0] CMD_SENS      = 32'h53454e53;
  localparam logic [31:0] CMD_REF_MODE  = 32'h464d4f44;
  localparam logic [31:0] CMD_FREQ      = 32'h46524551;
  localparam logic [4:0]  SENS_RESET    = 5'h19;
  localparam logic [4:0]  SENS_100MV    = 5'h19;
  localparam logic [4:0]  SENS_50MV     = 5'h18;
  localparam logic [19:0] FS_100MV_UV   = 20'h186a0;
  localparam logic [19:0] FS_50MV_UV    = 20'h0c350;
  localparam logic [2:0]  REF_MODE_RESET = 3'h0;
  localparam logic [19:0] FREQ_RESET    = 20'h003e8;
  typedef enum logic [3:0] {
    S_COLLECT = 4'h0,
    S_FETCH   = 4'h1,
    S_WAIT    = 4'h2,
    S_PARSE   = 4'h3,
    S_EXEC    = 4'h4,
    S_DIGIT   = 4'h5,
    S_SEND    = 4'h6,
    S_CR      = 4'h7
  } scp_state_e;
endpackage

//--- scp_serial_command_parser.sv
// Remote command interpreter: serial receiver, line buffer, parser, reply sender.
// Assumes rx_in is synchronous to clk_in and overload inputs are clean levels.
`timescale 1ns/1ns
module scp_serial_command_parser (
  input  wire logic                   clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   ce_in,
  input  wire logic                   rx_in,
  output logic                        tx_out,
  input  wire logic                   ovl_input_in,
  input  wire logic                   ovl_gain_in,
  output logic                        ovl_input_flag_out,
  output logic                        ovl_gain_flag_out,
  output logic [4:0]                  sens_code_out,
  output logic [scp_pkg::VAL_W-1:0]   sens_full_scale_uv_out,
  output logic [2:0]                  ref_mode_out,
  output logic [scp_pkg::VAL_W-1:0]   freq_out,
  output logic                        display_update_out,
  output logic                        busy_out
);
  import scp_pkg::*;

  function automatic logic [VAL_W-1:0] pow10(input logic [2:0] idx);
    case (idx)
      3'h0:    pow10 = 20'h00001;
      3'h1:    pow10 = 20'h0000a;
      3'h2:    pow10 = 20'h00064;
      3'h3:    pow10 = 20'h003e8;
      3'h4:    pow10 = 20'h02710;
      3'h5:    pow10 = 20'h186a0;
      3'h6:    pow10 = 20'hf4240;
      default: pow10 = 20'h00001;
    endcase
  endfunction

  function automatic logic [VAL_W-1:0] sens_to_uv(input logic [4:0] code);
    case (code)
      SENS_100MV: sens_to_uv = FS_100MV_UV;
      SENS_50MV:  sens_to_uv = FS_50MV_UV;
      default:    sens_to_uv = 20'h00000;
    endcase
  endfunction

  scp_mem_if mem_bus ();
  scp_line_mem u_mem (
    .clk_in (clk_in),
    .ce_in  (ce_in),
    .port   (mem_bus.mem)
  );

  // Receiver
  logic [4:0]  rx_cnt_reg;
  logic [3:0]  rx_bit_reg;
  logic [7:0]  rx_shift_reg;
  logic        rx_active_reg;
  logic        rx_valid_reg;
  wire  logic  rx_tick = (rx_cnt_reg == 5'h00);
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_cnt_reg    <= 5'h00;
      rx_bit_reg    <= 4'h0;
      rx_shift_reg  <= 8'h00;
      rx_active_reg <= 1'b0;
      rx_valid_reg  <= 1'b0;
    end else if (ce_in) begin
      rx_valid_reg <= 1'b0;
      if (!rx_active_reg) begin
        if (!rx_in) begin
          rx_active_reg <= 1'b1;
          rx_bit_reg    <= 4'h0;
          rx_cnt_reg    <= 5'(HALF_CYCLES);
        end
      end else if (!rx_tick) begin
        rx_cnt_reg <= rx_cnt_reg - 5'h01;
      end else begin
        rx_cnt_reg <= 5'(BIT_CYCLES - 1);
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0) begin
          rx_active_reg <= ~rx_in;  // False start rejected
        end else if (rx_bit_reg <= 4'(DATA_BITS)) begin
          rx_shift_reg <= {rx_in, rx_shift_reg[7:1]};
        end else begin
          rx_active_reg <= 1'b0;
          rx_valid_reg  <= rx_in;
        end
      end
    end
  end

  // Transmitter
  logic [9:0]  tx_shift_reg;
  logic [3:0]  tx_bits_reg;
  logic [4:0]  tx_cnt_reg;
  logic        tx_start;
  logic [7:0]  tx_byte;
  wire  logic  tx_busy = (tx_bits_reg != 4'h0);
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_shift_reg <= 10'h3ff;
      tx_bits_reg  <= 4'h0;
      tx_cnt_reg   <= 5'h00;
    end else if (ce_in) begin
      if (tx_start) begin
        tx_shift_reg <= {1'b1, tx_byte, 1'b0};
        tx_bits_reg  <= 4'ha;
        tx_cnt_reg   <= 5'(BIT_CYCLES - 1);
      end else if (tx_busy) begin
        if (tx_cnt_reg == 5'h00) begin
          tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
          tx_bits_reg  <= tx_bits_reg - 4'h1;
          tx_cnt_reg   <= 5'(BIT_CYCLES - 1);
        end else begin
          tx_cnt_reg <= tx_cnt_reg - 5'h01;
        end
      end
    end
  end
  assign tx_out = tx_shift_reg[0];

  // Parser state
  scp_state_e        state_reg;
  logic [ADDR_W-1:0] wr_ptr_reg;
  logic [ADDR_W-1:0] len_reg;
  logic [ADDR_W-1:0] rd_ptr_reg;
  logic [31:0]       mn_reg;
  logic [2:0]        mn_cnt_reg;
  logic [VAL_W-1:0]  val_reg;
  logic              query_reg;
  logic [VAL_W-1:0]  rem_reg;
  logic [2:0]        idx_reg;
  logic [3:0]        digit_reg;
  logic              started_reg;
  logic [4:0]        sens_reg;
  logic [2:0]        mode_reg;
  logic [VAL_W-1:0]  freq_reg;
  logic [VAL_W-1:0]  fs_reg;
  logic              upd_reg;
  logic [1:0]        ovl_reg;

  wire logic [7:0]       ch        = mem_bus.rd_data;
  wire logic             ch_digit  = (ch >= CH_ZERO) && (ch <= CH_NINE);
  wire logic [VAL_W-1:0] val_next  = VAL_W'({val_reg, 3'h0}) + VAL_W'({val_reg, 1'h0})
                                     + VAL_W'(ch - CH_ZERO);
  wire logic             is_sens   = (mn_reg == CMD_SENS);
  wire logic             is_mode   = (mn_reg == CMD_REF_MODE);
  wire logic             is_freq   = (mn_reg == CMD_FREQ);
  wire logic [VAL_W-1:0] cur_pow   = pow10(idx_reg);
  wire logic             rem_ge    = (rem_reg >= cur_pow);
  wire logic             emit      = (digit_reg != 4'h0) || started_reg || (idx_reg == 3'h0);
  wire logic [VAL_W-1:0] query_val = is_sens ? VAL_W'(sens_reg) :
                                     is_mode ? VAL_W'(mode_reg) : freq_reg;
  wire logic             line_full = (wr_ptr_reg == LINE_MAX);
  wire logic             rx_take   = rx_valid_reg && (state_reg == S_COLLECT);

  assign mem_bus.wr_en   = rx_take && (rx_shift_reg != CH_CR) && !line_full;
  assign mem_bus.wr_addr = wr_ptr_reg;
  assign mem_bus.wr_data = rx_shift_reg;
  assign mem_bus.rd_addr = rd_ptr_reg;
  assign tx_start = !tx_busy && ((state_reg == S_SEND) || (state_reg == S_CR));
  assign tx_byte  = (state_reg == S_CR) ? CH_CR : (CH_ZERO + 8'(digit_reg));

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg   <= S_COLLECT;
      wr_ptr_reg  <= '0;
      len_reg     <= '0;
      rd_ptr_reg  <= '0;
      mn_reg      <= 32'h00000000;
      mn_cnt_reg  <= 3'h0;
      val_reg     <= '0;
      query_reg   <= 1'b0;
      rem_reg     <= '0;
      idx_reg     <= 3'h0;
      digit_reg   <= 4'h0;
      started_reg <= 1'b0;
      sens_reg    <= SENS_RESET;
      mode_reg    <= REF_MODE_RESET;
      freq_reg    <= FREQ_RESET;
      fs_reg      <= sens_to_uv(SENS_RESET);
      upd_reg     <= 1'b0;
    end else if (ce_in) begin
      upd_reg <= 1'b0;
      case (state_reg)
        S_COLLECT: begin
          if (rx_take) begin
            if (rx_shift_reg == CH_CR) begin
              len_reg    <= wr_ptr_reg;
              wr_ptr_reg <= '0;
              rd_ptr_reg <= '0;
              state_reg  <= S_FETCH;
            end else if (!line_full) begin
              wr_ptr_reg <= wr_ptr_reg + ADDR_W'(1);
            end
          end
        end
        S_FETCH: begin
          if (rd_ptr_reg == len_reg) begin
            state_reg <= (mn_cnt_reg != 3'h0) ? S_EXEC : S_COLLECT;
          end else begin
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          state_reg <= S_PARSE;
        end
        S_PARSE: begin
          rd_ptr_reg <= rd_ptr_reg + ADDR_W'(1);
          state_reg  <= S_FETCH;
          if (ch == CH_SEMI) begin
            state_reg <= S_EXEC;
          end else if (ch == CH_SPACE) begin
            state_reg <= S_FETCH;
          end else if (mn_cnt_reg != 3'h4) begin
            mn_reg     <= {mn_reg[23:0], ch};
            mn_cnt_reg <= mn_cnt_reg + 3'h1;
          end else if (ch == CH_QUERY) begin
            query_reg <= 1'b1;
          end else if (ch_digit) begin
            val_reg <= val_next;
          end
        end
        S_EXEC: begin
          mn_cnt_reg <= 3'h0;
          mn_reg     <= 32'h00000000;
          val_reg    <= '0;
          query_reg  <= 1'b0;
          state_reg  <= S_FETCH;
          if (query_reg && (is_sens || is_mode || is_freq)) begin
            rem_reg     <= query_val;
            idx_reg     <= 3'(DIGITS - 1);
            digit_reg   <= 4'h0;
            started_reg <= 1'b0;
            state_reg   <= S_DIGIT;
          end else if (!query_reg) begin
            upd_reg <= is_sens || is_mode || is_freq;
            if (is_sens) begin
              sens_reg <= val_reg[4:0];
              // Full scale kept in step with the code, so the output is a flop
              fs_reg   <= sens_to_uv(val_reg[4:0]);
            end
            if (is_mode) begin
              mode_reg <= val_reg[2:0];
            end
            if (is_freq) begin
              freq_reg <= val_reg;
            end
          end
        end
        S_DIGIT: begin
          if (rem_ge) begin
            rem_reg   <= rem_reg - cur_pow;
            digit_reg <= digit_reg + 4'h1;
          end else if (emit) begin
            state_reg <= S_SEND;
          end else begin
            idx_reg <= idx_reg - 3'h1;
          end
        end
        S_SEND: begin
          if (tx_start) begin
            started_reg <= 1'b1;
            digit_reg   <= 4'h0;
            idx_reg     <= idx_reg - 3'h1;
            state_reg   <= (idx_reg == 3'h0) ? S_CR : S_DIGIT;
          end
        end
        S_CR: begin
          if (tx_start) begin
            state_reg <= S_FETCH;
          end
        end
        default: begin
          state_reg <= S_COLLECT;
        end
      endcase
    end
  end

  // Two flags kept apart so both can show at once
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ovl_reg <= 2'h0;
    end else if (ce_in) begin
      ovl_reg <= {ovl_gain_in, ovl_input_in};
    end
  end

  assign ovl_input_flag_out     = ovl_reg[0];
  assign ovl_gain_flag_out      = ovl_reg[1];
  assign sens_code_out          = sens_reg;
  assign sens_full_scale_uv_out = fs_reg;
  assign ref_mode_out           = mode_reg;
  assign freq_out               = freq_reg;
  assign display_update_out     = upd_reg;
  assign busy_out               = (state_reg != S_COLLECT);
endmodule // scp_serial_command_parser

//--- tb.sv
// Self-checking bench for the serial command parser.
// Assumes the host model owns the serial lines; ce_in drops only while the link is idle.
`timescale 1ns/1ns
module tb;
  import scp_pkg::*;
  logic             clk_in, sys_rst_in, ovl_input_in, ovl_gain_in, rx_line, tx_line, oi_f, og_f, upd, busy;
  logic             run = 1'b0;
  logic             ce = 1'b1, ce_d = 1'b1;
  logic [4:0]       sens;
  logic [2:0]       mode;
  logic [VAL_W-1:0] fs, freq;
  int               fails, comparisons, upd_cnt, upd_exp, sens_m, mode_m, freq_m, seed = 45;
  byte unsigned     exp_q[$];
  string            sm, mm, fm;
  scp_serial_command_parser scp_serial_command_parser_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce), .rx_in(rx_line), .tx_out(tx_line),
    .ovl_input_in(ovl_input_in), .ovl_gain_in(ovl_gain_in), .ovl_input_flag_out(oi_f), .ovl_gain_flag_out(og_f),
    .sens_code_out(sens), .sens_full_scale_uv_out(fs), .ref_mode_out(mode), .freq_out(freq),
    .display_update_out(upd), .busy_out(busy));
  scp_host_model scp_host_model_inst (.clk_in(clk_in), .line_in(tx_line), .line_out(rx_line));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    upd_cnt += (upd === 1'b1);
    ce_d = ce;
  end
  // Flags only follow the inputs across an edge with the enable high
  always @(negedge clk_in) begin
    if (run && ce_d) begin
      check("ovl_input", oi_f, ovl_input_in);
      check("ovl_gain", og_f, ovl_gain_in);
    end
    {ovl_input_in, ovl_gain_in} = 2'($random(seed));
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  task automatic push_num(input int v);
    string t;
    t = $sformatf("%0d", v);
    foreach (t[i]) exp_q.push_back(t[i]);
    exp_q.push_back(CH_CR);
  endtask
  task automatic model_cmd(input string c);
    string m;
    int    v;
    bit    q;
    m = "";
    v = 0;
    q = 0;
    foreach (c[i]) begin
      if (c[i] == " ") continue;
      if (m.len() < 4) m = {m, c.substr(i, i)};
      else if (c[i] == "?") q = 1;
      else if (c[i] >= "0" && c[i] <= "9") v = (v * 10 + c[i] - "0") % 1048576;
    end
    if (q) begin
      if (m == sm) push_num(sens_m);
      if (m == mm) push_num(mode_m);
      if (m == fm) push_num(freq_m);
    end else begin
      if (m == sm) sens_m = v % 32;
      if (m == mm) mode_m = v % 8;
      if (m == fm) freq_m = v;
      if (m == sm || m == mm || m == fm) upd_exp++;
    end
  endtask
  // Only the first 63 line characters are kept
  task automatic model_line(input string s);
    int b;
    b = 0;
    if (s.len() > 63) s = s.substr(0, 62);
    for (int i = 0; i <= s.len(); i++) begin
      if (i == s.len() || s[i] == ";") begin
        model_cmd(s.substr(b, i - 1));
        b = i + 1;
      end
    end
  endtask
  task automatic check_vals();
    check("sens", sens, sens_m);
    check("full_scale", fs, sens_m == 25 ? 100000 : sens_m == 24 ? 50000 : 0);
    check("mode", mode, mode_m);
    check("freq", freq, freq_m);
    check("updates", upd_cnt, upd_exp);
  endtask
  task automatic do_line(input string s, input int gap, input int bad);
    int k;
    scp_host_model_inst.send_line(s, gap, bad);
    model_line(bad < 0 ? s : {s.substr(0, bad - 1), s.substr(bad + 1, s.len() - 1)});
    k = 0;
    while (busy !== 1'b0 && k < 30000) begin
      @(negedge clk_in);
      k++;
    end
    if (busy !== 1'b0) begin
      fails++;
      report_and_stop();
    end
    k = 0;
    while (scp_host_model_inst.rx_q.size() < exp_q.size() && k < 1000) begin
      @(negedge clk_in);
      k++;
    end
    check("reply_len", scp_host_model_inst.rx_q.size(), exp_q.size());
    while (exp_q.size() > 0 && scp_host_model_inst.rx_q.size() > 0)
      check("reply", scp_host_model_inst.rx_q.pop_front(), exp_q.pop_front());
    exp_q.delete();
    scp_host_model_inst.rx_q.delete();
    check_vals();
  endtask
  task automatic do_reset();
    run <= 1'b0;
    sys_rst_in = 1'b1;
    repeat (8) @(negedge clk_in);
    sys_rst_in = 1'b0;
    sens_m = 25;
    mode_m = 0;
    freq_m = 1000;
    @(negedge clk_in);
    run <= 1'b1;
    upd_cnt = 0;
    upd_exp = 0;
    check("tx_idle", tx_line, 1);
    check_vals();
  endtask
  // Enable low while idle: flags must hold although the inputs keep moving
  task automatic freeze(input int n);
    logic [1:0] f;
    ce = 1'b0;
    f = {og_f, oi_f};
    repeat (n) @(negedge clk_in);
    check("frozen_ovl", {og_f, oi_f}, f);
    ce = 1'b1;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    ovl_input_in = 1'b0;
    ovl_gain_in = 1'b0;
    sm = $sformatf("%s", CMD_SENS);
    mm = $sformatf("%s", CMD_REF_MODE);
    fm = $sformatf("%s", CMD_FREQ);
    do_reset();
    do_line({sm, " 24;", mm, " 1;", fm, " 1000;", sm, " ?;", mm, " ?;", fm, " ?"}, 0, -1);
    freeze(50);
    for (int i = 0; i < 2; i++) begin
      do_line($sformatf("%s %0d;%s?;AB;%s %0d;%s %0d;%s ?;%s ?", sm, {$random(seed)} % 32, sm, mm,
        {$random(seed)} % 10, fm, {$random(seed)} % 2000000, fm, mm), i * 20, -1);
    end
    // Long gap lets a framing error settle before the next start bit
    do_line({fm, " 573;", sm, " 25"}, 300, 6);
    do_line({fm, " 77", {56{" "}}, ";", sm, " 24"}, 0, -1);
    do_reset();
    do_line({sm, " ?"}, 0, -1);
    check("stop_bits", scp_host_model_inst.bad_stop, 0);
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    fails++;
    report_and_stop();
  end
endmodule // tb
bind scp_serial_command_parser scp_asserts scp_asserts_inst (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .rx_in(rx_in), .tx_out(tx_out),
  .ovl_input_in(ovl_input_in), .ovl_gain_in(ovl_gain_in), .ovl_input_flag_out(ovl_input_flag_out),
  .ovl_gain_flag_out(ovl_gain_flag_out), .sens_code_out(sens_code_out),
  .sens_full_scale_uv_out(sens_full_scale_uv_out), .ref_mode_out(ref_mode_out), .freq_out(freq_out),
  .display_update_out(display_update_out), .busy_out(busy_out));
